// ### include/atd_pkg.sv
// Purpose: Shared constants for the analog trim datapath.
// Assumes: One clock, synchronous active-high reset, APB register access.
// Notes:   Byte offsets are APB byte addresses of 32-bit aligned words.
`default_nettype none

package atd_pkg;

    // ------------------------------------------------------------------
    // Datapath sizes
    // ------------------------------------------------------------------
    localparam int                 ATD_CODE_W   = 12;
    localparam logic [11:0]        ATD_CODE_MAX = 12'hfff;
    localparam int                 ATD_GAIN_W   = 16;
    localparam int                 ATD_OFS_W    = 8;
    localparam logic signed [15:0] ATD_OFS_LIM  = 16'sh0064;
    localparam logic signed [31:0] ATD_GAIN_DEN = 32'sh0000_2710;
    localparam logic signed [31:0] ATD_GAIN_RND = 32'sh0000_1388;
    localparam int                 ATD_IN_CH    = 8;
    localparam int                 ATD_OUT_CH   = 4;
    localparam int                 ATD_AVG_MAX  = 8;
    localparam int                 ATD_AVG_W    = 4;
    localparam int                 ATD_SUM_W    = 15;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ATD_CTRL_OFS      = 12'h000;
    localparam logic [11:0] ATD_STAT_OFS      = 12'h004;
    localparam logic [11:0] ATD_OUT_SET_OFS   = 12'h008;
    localparam logic [11:0] ATD_OUT_CODE_BASE = 12'h010;
    localparam logic [11:0] ATD_IN_RES_BASE   = 12'h020;
    localparam logic [11:0] ATD_IN_GAIN_BASE  = 12'h040;
    localparam logic [11:0] ATD_IN_OFS_BASE   = 12'h060;
    localparam logic [11:0] ATD_OUT_GAIN_BASE = 12'h080;
    localparam logic [11:0] ATD_OUT_OFS_BASE  = 12'h090;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int                  ATD_CTRL_REBOOT_BIT = 0;
    localparam int                  ATD_CTRL_AVG_LSB    = 4;
    localparam int                  ATD_STAT_PEND_BIT   = 0;
    localparam int                  ATD_STAT_AVG_LSB    = 4;
    localparam int                  ATD_OUT_SET_CH_LSB  = 12;
    localparam logic [ATD_AVG_W-1:0] ATD_AVG_RST        = 4'h1;

    // Limits a written zero offset to the allowed band.
    function automatic logic signed [7:0] atd_clamp_ofs(input logic [15:0] raw);
        logic signed [15:0] val;
        val = $signed(raw);
        if (val > ATD_OFS_LIM)
            return ATD_OFS_LIM[7:0];
        else if (val < -ATD_OFS_LIM)
            return 8'sh9c;
        else
            return val[7:0];
    endfunction : atd_clamp_ofs

    // Limits a written point count to 1..ATD_AVG_MAX.
    function automatic logic [3:0] atd_clamp_avg(input logic [3:0] raw);
        if (raw == 4'h0)
            return 4'h1;
        else if (raw > 4'h8)
            return 4'h8;
        else
            return raw;
    endfunction : atd_clamp_avg

endpackage : atd_pkg

`default_nettype wire

// ### rtl/atd_trim_calc.sv
// Purpose: Applies gain trim, then zero offset, then saturation to a code.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Gain is (1 + g/10000), rounded to nearest for positive products.
`default_nettype none

module atd_trim_calc
    import atd_pkg::*;
(
    // Operands
    input  wire logic        [11:0] rawCode,
    input  wire logic signed [15:0] gainTrim,
    input  wire logic signed [7:0]  zeroOfs,
    // Result
    output logic             [11:0] trimmedCode
);

    logic signed [31:0] factor;
    logic signed [31:0] product;
    logic signed [31:0] scaled;
    logic signed [31:0] total;

    always_comb
    begin
        factor  = ATD_GAIN_DEN + 32'(gainTrim);
        product = $signed({20'h0, rawCode}) * factor;
        scaled  = (product + ATD_GAIN_RND) / ATD_GAIN_DEN;
        total   = scaled + 32'(zeroOfs);
        if (total < 32'sd0)
            trimmedCode = 12'h000;
        else if (total > $signed({20'h0, ATD_CODE_MAX}))
            trimmedCode = ATD_CODE_MAX;
        else
            trimmedCode = total[11:0];
    end

endmodule : atd_trim_calc

`default_nettype wire

// ### rtl/atd_trim_datapath.sv
// Purpose: Trim and averaging datapath between software and the converters.
// Assumes: ADC samples arrive as a valid/channel/data stream on core_clk.
// Notes:   Trim constants written over APB act only after a cold boot.
//
// What this block does
// - Accept channel plus 12-bit output code.
// - Hold each output code until rewritten or cleared to zero by a boot.
// - Zero trims pass codes through unchanged.
// - Scale input average by one plus g/10000.
// - Trims take effect only at cold boot.
// - Add input zero offset, limited to 100.
// - Scale output code by one plus h/10000.
// - Add output zero offset, limited to 100.
// - Input result is N-point moving average.
// - One point returns latest raw sample.
// - Four independent 12-bit output channels.
//
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none

module atd_trim_datapath
    import atd_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // ADC sample stream
    input  wire logic                  adcValid,
    input  wire logic [2:0]            adcChan,
    input  wire logic [11:0]           adcData,
    // Corrected input results
    output logic                       inResValid,
    output logic      [2:0]            inResChan,
    output logic      [11:0]           inResData,
    // Current-output converter codes
    output logic [ATD_OUT_CH-1:0][11:0] dacCode,
    output logic [ATD_OUT_CH-1:0]       dacLoad
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic signed [15:0] inGainStgQ  [ATD_IN_CH];
    logic signed [7:0]  inOfsStgQ   [ATD_IN_CH];
    logic signed [15:0] outGainStgQ [ATD_OUT_CH];
    logic signed [7:0]  outOfsStgQ  [ATD_OUT_CH];
    logic [3:0]         avgStgQ;
    logic signed [15:0] inGainQ     [ATD_IN_CH];
    logic signed [7:0]  inOfsQ      [ATD_IN_CH];
    logic signed [15:0] outGainQ    [ATD_OUT_CH];
    logic signed [7:0]  outOfsQ     [ATD_OUT_CH];
    logic [3:0]         avgQ;
    logic               bootQ;
    logic               pendQ;
    logic [11:0]        inResQ      [ATD_IN_CH];
    logic [31:0]        prdataQ;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic       apbWrite;
    logic       hitCtrl;
    logic       hitStat;
    logic       hitOutSet;
    logic       hitOutCode;
    logic       hitInRes;
    logic       hitInGain;
    logic       hitInOfs;
    logic       hitOutGain;
    logic       hitOutOfs;
    logic       hitAny;
    logic       calWrite;
    logic [2:0] inSel;
    logic [1:0] outSel;

    assign inSel      = paddr[4:2];
    assign outSel     = paddr[3:2];
    assign hitCtrl    = paddr == ATD_CTRL_OFS;
    assign hitStat    = paddr == ATD_STAT_OFS;
    assign hitOutSet  = paddr == ATD_OUT_SET_OFS;
    assign hitOutCode = paddr[11:4] == ATD_OUT_CODE_BASE[11:4] && paddr[1:0] == 2'b00;
    assign hitInRes   = paddr[11:5] == ATD_IN_RES_BASE[11:5] && paddr[1:0] == 2'b00;
    assign hitInGain  = paddr[11:5] == ATD_IN_GAIN_BASE[11:5] && paddr[1:0] == 2'b00;
    assign hitInOfs   = paddr[11:5] == ATD_IN_OFS_BASE[11:5] && paddr[1:0] == 2'b00;
    assign hitOutGain = paddr[11:4] == ATD_OUT_GAIN_BASE[11:4] && paddr[1:0] == 2'b00;
    assign hitOutOfs  = paddr[11:4] == ATD_OUT_OFS_BASE[11:4] && paddr[1:0] == 2'b00;
    assign hitAny     = hitCtrl | hitStat | hitOutSet | hitOutCode | hitInRes
                      | hitInGain | hitInOfs | hitOutGain | hitOutOfs;

    // The setup cycle loads read data, so no access needs a wait state.
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~hitAny;
    assign prdata   = prdataQ;
    assign apbWrite = psel & penable & pwrite & hitAny;
    assign calWrite = apbWrite & (hitInGain | hitInOfs | hitOutGain | hitOutOfs
                    | hitCtrl);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdataQ <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
        begin
            prdataQ <= 32'h0000_0000;
            if (hitCtrl)
                prdataQ[ATD_CTRL_AVG_LSB +: ATD_AVG_W] <= avgStgQ;
            else if (hitStat)
            begin
                prdataQ[ATD_STAT_PEND_BIT]                 <= pendQ;
                prdataQ[ATD_STAT_AVG_LSB +: ATD_AVG_W]     <= avgQ;
            end
            else if (hitOutCode)
                prdataQ[11:0] <= dacCode[outSel];
            else if (hitInRes)
                prdataQ[11:0] <= inResQ[inSel];
            else if (hitInGain)
                prdataQ <= 32'(inGainStgQ[inSel]);
            else if (hitInOfs)
                prdataQ <= 32'(inOfsStgQ[inSel]);
            else if (hitOutGain)
                prdataQ <= 32'(outGainStgQ[outSel]);
            else if (hitOutOfs)
                prdataQ <= 32'(outOfsStgQ[outSel]);
        end
    end

    // ------------------------------------------------------------------
    // Staged trim constants and cold boot
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < ATD_IN_CH; i++)
            begin
                inGainStgQ[i] <= 16'sh0000;
                inOfsStgQ[i]  <= 8'sh00;
            end
            for (int i = 0; i < ATD_OUT_CH; i++)
            begin
                outGainStgQ[i] <= 16'sh0000;
                outOfsStgQ[i]  <= 8'sh00;
            end
            avgStgQ <= ATD_AVG_RST;
        end
        else if (apbWrite)
        begin
            if (hitInGain)
                inGainStgQ[inSel] <= $signed(pwdata[15:0]);
            if (hitInOfs)
                inOfsStgQ[inSel] <= atd_clamp_ofs(pwdata[15:0]);
            if (hitOutGain)
                outGainStgQ[outSel] <= $signed(pwdata[15:0]);
            if (hitOutOfs)
                outOfsStgQ[outSel] <= atd_clamp_ofs(pwdata[15:0]);
            if (hitCtrl)
                avgStgQ <= atd_clamp_avg(pwdata[ATD_CTRL_AVG_LSB +: ATD_AVG_W]);
        end
    end

    // Boot runs the cycle after reset release and on a software reboot.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            bootQ <= 1'b1;
        else
            bootQ <= apbWrite & hitCtrl & pwdata[ATD_CTRL_REBOOT_BIT];
    end

    // Pending flag: a new staged write in the boot cycle stays pending.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pendQ <= 1'b0;
        else if (calWrite)
            pendQ <= 1'b1;
        else if (bootQ)
            pendQ <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < ATD_IN_CH; i++)
            begin
                inGainQ[i] <= 16'sh0000;
                inOfsQ[i]  <= 8'sh00;
            end
            for (int i = 0; i < ATD_OUT_CH; i++)
            begin
                outGainQ[i] <= 16'sh0000;
                outOfsQ[i]  <= 8'sh00;
            end
            avgQ <= ATD_AVG_RST;
        end
        else if (bootQ)
        begin
            inGainQ  <= inGainStgQ;
            inOfsQ   <= inOfsStgQ;
            outGainQ <= outGainStgQ;
            outOfsQ  <= outOfsStgQ;
            avgQ     <= avgStgQ;
        end
    end

    // ------------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------------
    logic        outReqQ;
    logic [1:0]  outChQ;
    logic [11:0] outCodeQ;
    logic [11:0] outTrimmed;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            outReqQ  <= 1'b0;
            outChQ   <= 2'b00;
            outCodeQ <= 12'h000;
        end
        else
        begin
            outReqQ <= apbWrite & hitOutSet;
            if (apbWrite & hitOutSet)
            begin
                outChQ   <= pwdata[ATD_OUT_SET_CH_LSB +: 2];
                outCodeQ <= pwdata[11:0];
            end
        end
    end

    atd_trim_calc outTrim
    (
        .rawCode     (outCodeQ),
        .gainTrim    (outGainQ[outChQ]),
        .zeroOfs     (outOfsQ[outChQ]),
        .trimmedCode (outTrimmed)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst || bootQ)
        begin
            dacCode <= '0;
            dacLoad <= '0;
        end
        else
        begin
            for (int i = 0; i < ATD_OUT_CH; i++)
            begin
                dacLoad[i] <= outReqQ && outChQ == 2'(i);
                if (outReqQ && outChQ == 2'(i))
                    dacCode[i] <= outTrimmed;
            end
        end
    end

    // ------------------------------------------------------------------
    // Input path: sample window and moving average
    // ------------------------------------------------------------------
    logic [11:0]          winQ  [ATD_IN_CH][ATD_AVG_MAX];
    logic [3:0]           fillQ [ATD_IN_CH];
    logic                 avgValidQ;
    logic [2:0]           avgChQ;
    logic [3:0]           effN;
    logic [ATD_SUM_W-1:0] winSum;
    logic [ATD_SUM_W-1:0] avgWide;
    logic [11:0]          avgCode;
    logic [11:0]          inTrimmed;

    always_ff @(posedge core_clk)
    begin
        if (adcValid)
            for (int k = 0; k < ATD_AVG_MAX; k++)
                winQ[adcChan][k] <= (k == 0) ? adcData : winQ[adcChan][k > 0 ? k-1 : 0];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || bootQ)
        begin
            for (int i = 0; i < ATD_IN_CH; i++)
                fillQ[i] <= 4'h0;
            avgValidQ <= 1'b0;
            avgChQ    <= 3'b000;
        end
        else
        begin
            avgValidQ <= adcValid;
            if (adcValid)
            begin
                avgChQ <= adcChan;
                if (fillQ[adcChan] != 4'h8)
                    fillQ[adcChan] <= fillQ[adcChan] + 4'h1;
            end
        end
    end

    // Averages over the samples held so far until the window has filled.
    always_comb
    begin
        effN   = (fillQ[avgChQ] < avgQ) ? fillQ[avgChQ] : avgQ;
        winSum = '0;
        for (int k = 0; k < ATD_AVG_MAX; k++)
            if (4'(k) < effN)
                winSum = winSum + ATD_SUM_W'(winQ[avgChQ][k]);
        if (effN <= 4'h1)
            avgWide = ATD_SUM_W'(winQ[avgChQ][0]);
        else
            avgWide = winSum / ATD_SUM_W'(effN);
        avgCode = avgWide[11:0];
    end

    atd_trim_calc inTrim
    (
        .rawCode     (avgCode),
        .gainTrim    (inGainQ[avgChQ]),
        .zeroOfs     (inOfsQ[avgChQ]),
        .trimmedCode (inTrimmed)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst || bootQ)
        begin
            for (int i = 0; i < ATD_IN_CH; i++)
                inResQ[i] <= 12'h000;
            inResValid <= 1'b0;
            inResChan  <= 3'b000;
            inResData  <= 12'h000;
        end
        else
        begin
            inResValid <= avgValidQ;
            if (avgValidQ)
            begin
                inResQ[avgChQ] <= inTrimmed;
                inResChan      <= avgChQ;
                inResData      <= inTrimmed;
            end
        end
    end

endmodule : atd_trim_datapath

`default_nettype wire

// ### verif/atd_conv_model.sv
// Purpose: Converter model: ADC sample source and current-output sink.
// Assumes: The bench calls the sample task; one sample per call.
// Notes:   Idle ADC lines carry the inverse of the last sample.
`default_nettype none

module atd_conv_model
    import atd_pkg::*;
(
    // Clock
    input  wire logic                        core_clk,
    // Converter codes
    input  wire logic [ATD_OUT_CH-1:0][11:0] dacCode,
    input  wire logic [ATD_OUT_CH-1:0]       dacLoad,
    // Sample stream
    output logic                             adcValid,
    output logic      [2:0]                  adcChan,
    output logic      [11:0]                 adcData
);
    timeunit 1ns;
    timeprecision 1ps;

    // Output current of each channel in microamps.
    int outUa [ATD_OUT_CH];

    initial
    begin
        adcValid = 1'b0;
        adcChan  = 3'h0;
        adcData  = 12'h000;
    end

    always @(posedge core_clk)
        for (int i = 0; i < ATD_OUT_CH; i++)
            if (dacLoad[i] === 1'b1)
                outUa[i] <= int'(dacCode[i]) * 20000 / 4096;

    task automatic sample(input logic [2:0] ch, input logic [11:0] d);
        @(posedge core_clk);
        adcValid <= 1'b1;
        adcChan  <= ch;
        adcData  <= d;
        @(posedge core_clk);
        adcValid <= 1'b0;
        adcChan  <= ~ch;
        adcData  <= ~d;
    endtask : sample

endmodule : atd_conv_model

`default_nettype wire

// ### verif/atd_trim_datapath_chk.sv
// Purpose: Port-level timing checks of the trim datapath.
// Assumes: Bound to every instance of atd_trim_datapath.
// Notes:   Trimmed values are judged by the bench.
`default_nettype none

module atd_trim_datapath_chk
    import atd_pkg::*;
(
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // APB
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [31:0]                 prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr,
    // Streams
    input  wire logic                        adcValid,
    input  wire logic [2:0]                  adcChan,
    input  wire logic [11:0]                 adcData,
    input  wire logic                        inResValid,
    input  wire logic [2:0]                  inResChan,
    input  wire logic [11:0]                 inResData,
    input  wire logic [ATD_OUT_CH-1:0][11:0] dacCode,
    input  wire logic [ATD_OUT_CH-1:0]       dacLoad
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready differs from access phase");
    a_set_load: assert property (
        psel && penable && pwrite && paddr == ATD_OUT_SET_OFS
        |-> ##2 dacLoad == (4'h1 << $past(pwdata[13:12], 2)))
        else $error("output set did not load its channel");
    a_set_rdzero: assert property (
        psel && penable && !pwrite && paddr == ATD_OUT_SET_OFS |-> prdata == 32'h0 && !pslverr)
        else $error("output set register read nonzero");
    a_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("refused read returned data");
    a_code_hold: assert property (
        dacLoad == 4'h0 |-> $stable(dacCode) || dacCode == '0)
        else $error("converter code moved without load");
    a_load_onehot: assert property ($onehot0(dacLoad))
        else $error("several converter loads at once");
    a_res_cause: assert property (
        inResValid |-> $past(adcValid, 2) && inResChan == $past(adcChan, 2))
        else $error("result without matching sample");
    a_res_hold: assert property (
        !inResValid |-> $stable(inResData) || inResData == 12'h000)
        else $error("result data moved without valid");
    a_boot_quiet: assert property (
        $fell(rst) |-> (dacLoad == 4'h0 && dacCode == '0 && !inResValid) [*2])
        else $error("outputs active during boot");

    c_set: cover property (dacLoad != 4'h0);
    c_res: cover property (inResValid);
    c_err: cover property (pslverr);

endmodule : atd_trim_datapath_chk

bind atd_trim_datapath atd_trim_datapath_chk u_chk (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adcValid(adcValid),
    .adcChan(adcChan), .adcData(adcData), .inResValid(inResValid), .inResChan(inResChan),
    .inResData(inResData), .dacCode(dacCode), .dacLoad(dacLoad));

`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench of the trim datapath.
// Assumes: Trims follow sat(round(c*(10000+g)/10000)+ofs).
// Notes:   Expected results queue up and a monitor pops them.
`default_nettype none

module tb_top
    import atd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic                        adcValid, inResValid;
    logic [2:0]                  adcChan, inResChan;
    logic [11:0]                 paddr, adcData, inResData;
    logic [31:0]                 pwdata, prdata;
    logic [ATD_OUT_CH-1:0][11:0] dacCode;
    logic [ATD_OUT_CH-1:0]       dacLoad;
    int                          n_fail, cmp_count, seed, nAvg, k;
    int                          gIn [8], oIn [8], gOut [4], oOut [4], hist [8][$];
    int                          sgIn [8], soIn [8], sgOut [4], soOut [4];
    logic [32:0]                 rdQ [$];
    logic [14:0]                 dacQ [$], resQ [$];

    atd_trim_datapath u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adcValid(adcValid), .adcChan(adcChan), .adcData(adcData),
        .inResValid(inResValid), .inResChan(inResChan), .inResData(inResData),
        .dacCode(dacCode), .dacLoad(dacLoad));
    atd_conv_model u_conv (.core_clk(core_clk), .dacCode(dacCode), .dacLoad(dacLoad),
        .adcValid(adcValid), .adcChan(adcChan), .adcData(adcData));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [11:0] trim(input int c, input int g, input int o);
        int v;
        v = (c * (10000 + g) + 5000) / 10000 + o;
        return (v < 0) ? 12'h000 : (v > 4095) ? 12'hfff : 12'(v);
    endfunction : trim

    function automatic int lim(input int v);
        return (v > 100) ? 100 : (v < -100) ? -100 : v;
    endfunction : lim

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            complete_run();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        rdQ.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic setOut(input int ch, input logic [11:0] c);
        dacQ.push_back({2'(ch), trim(int'(c), gOut[ch], oOut[ch])});
        apb(1'b1, ATD_OUT_SET_OFS, {18'h0, 2'(ch), c});
    endtask : setOut

    task automatic adc(input logic [2:0] ch, input logic [11:0] d);
        int s;
        s = 0;
        hist[ch].push_back(int'(d));
        if (hist[ch].size() > nAvg)
            void'(hist[ch].pop_front());
        foreach (hist[ch][j])
            s += hist[ch][j];
        resQ.push_back({ch, trim(s / hist[ch].size(), gIn[ch], oIn[ch])});
        u_conv.sample(ch, d);
    endtask : adc

    // ------------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (psel && penable && !pwrite)
            check({pslverr, prdata}, rdQ.pop_front());
        for (int i = 0; i < 4; i++)
            if (dacLoad[i] === 1'b1)
                check({2'(i), dacCode[i]}, dacQ.pop_front());
        if (inResValid === 1'b1)
            check({inResChan, inResData}, resQ.pop_front());
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        n_fail    = 0;
        cmp_count = 0;
        seed      = 32'h9ef1;
        nAvg      = 1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(ATD_CTRL_OFS, 32'h10, 1'b0);
        rd(ATD_STAT_OFS, 32'h10, 1'b0);
        rd(ATD_OUT_SET_OFS, 32'h0, 1'b0);
        rd(12'h0a0, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++)
            setOut(i, 12'($random(seed)));
        setOut(1, 12'h800);
        repeat (4) @(posedge core_clk);
        check(33'(u_conv.outUa[1]), 33'd10000);
        for (int i = 0; i < 12; i++)
            adc(3'(i), 12'($random(seed)));
        for (int i = 0; i < 8; i++)
        begin
            sgIn[i] = $random(seed) % 201;
            soIn[i] = $random(seed) % 301;
            if (i < 4)
            begin
                sgOut[i] = $random(seed) % 201;
                soOut[i] = $random(seed) % 301;
            end
        end
        sgOut[1] = 146;
        soOut[1] = 200;
        soOut[2] = -300;
        soOut[3] = 0;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, ATD_IN_GAIN_BASE + 12'(4 * i), 32'(sgIn[i]));
            apb(1'b1, ATD_IN_OFS_BASE + 12'(4 * i), 32'(soIn[i]));
            if (i < 4)
            begin
                apb(1'b1, ATD_OUT_GAIN_BASE + 12'(4 * i), 32'(sgOut[i]));
                apb(1'b1, ATD_OUT_OFS_BASE + 12'(4 * i), 32'(soOut[i]));
            end
        end
        rd(ATD_STAT_OFS, 32'h11, 1'b0);
        rd(ATD_OUT_OFS_BASE + 12'h008, 32'(lim(soOut[2])), 1'b0);
        setOut(1, 12'hfff);
        adc(3'h5, 12'h80c);
        apb(1'b1, ATD_CTRL_OFS, 32'h41);
        repeat (4) @(posedge core_clk);
        nAvg = 4;
        for (int i = 0; i < 8; i++)
        begin
            gIn[i] = sgIn[i];
            oIn[i] = lim(soIn[i]);
            hist[i].delete();
            if (i < 4)
            begin
                gOut[i] = sgOut[i];
                oOut[i] = lim(soOut[i]);
            end
        end
        rd(ATD_STAT_OFS, 32'h40, 1'b0);
        rd(ATD_OUT_CODE_BASE + 12'h004, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            setOut(i, 12'h000);
            setOut(i, 12'hfff);
            setOut(i, 12'($random(seed)));
        end
        for (int i = 0; i < 40; i++)
            adc(3'($random(seed)), 12'($random(seed)));
        apb(1'b1, ATD_CTRL_OFS, 32'h0);
        rd(ATD_CTRL_OFS, 32'h10, 1'b0);
        k = 0;
        while ((dacQ.size() + resQ.size() + rdQ.size()) != 0 && k < 50)
        begin
            @(posedge core_clk);
            k++;
        end
        check(33'(dacQ.size() + resQ.size() + rdQ.size()), 33'h0);
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
